// *** common/scan_tap_pkg.sv ***
// Shared constants and types for the SRAM boundary-scan test port.
package scan_tap_pkg;

   // Register widths.
   localparam int unsigned IR_W  = 3;
   localparam int unsigned BSR_W = 75;
   localparam int unsigned ID_W  = 32;

   // Bit positions.
   localparam int unsigned LSB_POS = 0;
   localparam int unsigned BSR_MSB = BSR_W - 1;
   localparam int unsigned ID_MSB  = ID_W - 1;
   localparam int unsigned IR_MSB  = IR_W - 1;

   // Pattern loaded into the two low instruction bits on capture.
   localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;

   // Instruction codes of the five implemented instructions.
   localparam logic [IR_W-1:0] INS_EXTEST  = 3'h0;
   localparam logic [IR_W-1:0] INS_IDCODE  = 3'h1;
   localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
   localparam logic [IR_W-1:0] INS_SAMPLE  = 3'h4;
   localparam logic [IR_W-1:0] INS_BYPASS  = 3'h7;

   // Identification code; the value is arbitrary.
   localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0A5C_3E11;

   // Controller states.
   typedef enum logic [3:0] {
      ST_TLR   = 4'h0,
      ST_RTI   = 4'h1,
      ST_SELDR = 4'h2,
      ST_CAPDR = 4'h3,
      ST_SHDR  = 4'h4,
      ST_EX1DR = 4'h5,
      ST_PSDR  = 4'h6,
      ST_EX2DR = 4'h7,
      ST_UPDR  = 4'h8,
      ST_SELIR = 4'h9,
      ST_CAPIR = 4'hA,
      ST_SHIR  = 4'hB,
      ST_EX1IR = 4'hC,
      ST_PSIR  = 4'hD,
      ST_EX2IR = 4'hE,
      ST_UPIR  = 4'hF
   } tap_state_t;

endpackage

// *** rtl/sram_scan_tap.sv ***
// Capture-only boundary-scan test access port of the burst SRAM.
//
// Functional notes
// - Inputs sampled on rising test clock edge; outputs change on falling edge.
// - Undriven mode select reads as high through a pull-up.
// - Serial input enters the selected register MSB; undriven serial input reads high.
// - Selected register LSB drives the serial output, first out while shifting.
// - Serial output driven only in shift states, otherwise high impedance.
// - Five rising edges with mode select high reset the port, memory untouched.
// - Power-up resets the port internally, serial output starts undriven.
// - Current instruction connects exactly one register between input and output.
// - Instruction register is three bits and shifted serially.
// - Instruction preset to identification on power-up and on each reset state.
// - Capture-instruction loads binary 01 into the two lowest bits.
// - One-bit bypass register under bypass; cleared low on capture-data.
// - Boundary register is 75 bits covering all memory inputs and bidirectional pins.
// - Capture-data snapshots the pin ring; shift-data shifts it.
// - Ring instructions only capture; nothing is preloaded or injected.
// - Identification instruction captures a hardwired 32-bit code and shifts it out.
// - Shifted instruction becomes active only at update-instruction.
// - Sample-with-high-impedance selects the boundary register and floats memory outputs.
// - All-zero code acts as sample but floats memory outputs.
`timescale 1ns/10ps

module sram_scan_tap #(
   parameter logic [scan_tap_pkg::ID_W-1:0] ID_VALUE = scan_tap_pkg::ID_DEFAULT
) (
   input  wire logic                           clk_sys,
   input  wire logic                           reset,
   input  wire logic                           tck,
   input  wire logic                           tmsDrv,
   input  wire logic                           tmsDrvEn,
   input  wire logic                           tdiDrv,
   input  wire logic                           tdiDrvEn,
   output logic                                tdo,
   output logic                                tdoOe,
   input  wire logic [scan_tap_pkg::BSR_W-1:0] pinRing,
   output logic                                memOutHiZ
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin levels and test clock domain reset.

   logic tmsEff;
   logic tdiEff;
   logic rstS1_q;
   logic rstS2_q;
   logic tckRst;

   assign tmsEff = tmsDrvEn ? tmsDrv : 1'b1;
   assign tdiEff = tdiDrvEn ? tdiDrv : 1'b1;
   assign tckRst = rstS2_q;

   // Power-up reset is asserted at once and released on the test clock.
   always_ff @(posedge tck or posedge reset)
   begin
      if (reset)
      begin
         rstS1_q <= 1'b1;
         rstS2_q <= 1'b1;
      end
      else
      begin
         rstS1_q <= 1'b0;
         rstS2_q <= rstS1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Controller state machine.

   scan_tap_pkg::tap_state_t state_q;
   scan_tap_pkg::tap_state_t state_d;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         scan_tap_pkg::ST_TLR:   state_d = tmsEff ? scan_tap_pkg::ST_TLR   : scan_tap_pkg::ST_RTI;
         scan_tap_pkg::ST_RTI:   state_d = tmsEff ? scan_tap_pkg::ST_SELDR : scan_tap_pkg::ST_RTI;
         scan_tap_pkg::ST_SELDR: state_d = tmsEff ? scan_tap_pkg::ST_SELIR
                                                  : scan_tap_pkg::ST_CAPDR;
         scan_tap_pkg::ST_CAPDR: state_d = tmsEff ? scan_tap_pkg::ST_EX1DR : scan_tap_pkg::ST_SHDR;
         scan_tap_pkg::ST_SHDR:  state_d = tmsEff ? scan_tap_pkg::ST_EX1DR : scan_tap_pkg::ST_SHDR;
         scan_tap_pkg::ST_EX1DR: state_d = tmsEff ? scan_tap_pkg::ST_UPDR  : scan_tap_pkg::ST_PSDR;
         scan_tap_pkg::ST_PSDR:  state_d = tmsEff ? scan_tap_pkg::ST_EX2DR : scan_tap_pkg::ST_PSDR;
         scan_tap_pkg::ST_EX2DR: state_d = tmsEff ? scan_tap_pkg::ST_UPDR  : scan_tap_pkg::ST_SHDR;
         scan_tap_pkg::ST_UPDR:  state_d = tmsEff ? scan_tap_pkg::ST_SELDR : scan_tap_pkg::ST_RTI;
         scan_tap_pkg::ST_SELIR: state_d = tmsEff ? scan_tap_pkg::ST_TLR
                                                  : scan_tap_pkg::ST_CAPIR;
         scan_tap_pkg::ST_CAPIR: state_d = tmsEff ? scan_tap_pkg::ST_EX1IR : scan_tap_pkg::ST_SHIR;
         scan_tap_pkg::ST_SHIR:  state_d = tmsEff ? scan_tap_pkg::ST_EX1IR : scan_tap_pkg::ST_SHIR;
         scan_tap_pkg::ST_EX1IR: state_d = tmsEff ? scan_tap_pkg::ST_UPIR  : scan_tap_pkg::ST_PSIR;
         scan_tap_pkg::ST_PSIR:  state_d = tmsEff ? scan_tap_pkg::ST_EX2IR : scan_tap_pkg::ST_PSIR;
         scan_tap_pkg::ST_EX2IR: state_d = tmsEff ? scan_tap_pkg::ST_UPIR  : scan_tap_pkg::ST_SHIR;
         scan_tap_pkg::ST_UPIR:  state_d = tmsEff ? scan_tap_pkg::ST_SELDR : scan_tap_pkg::ST_RTI;
         default:                state_d = scan_tap_pkg::ST_TLR;
      endcase
   end

   always_ff @(posedge tck or posedge tckRst)
   begin
      if (tckRst)
         state_q <= scan_tap_pkg::ST_TLR;
      else
         state_q <= state_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction register and decode.

   logic [scan_tap_pkg::IR_W-1:0] irShift_q;
   logic [scan_tap_pkg::IR_W-1:0] irActive_q;
   logic                          inReset;
   logic                          capIr;
   logic                          shIr;
   logic                          upIr;
   logic                          selBsr;
   logic                          selId;
   logic                          selByp;
   logic                          hiZWant;

   assign inReset = (state_q == scan_tap_pkg::ST_TLR);
   assign capIr   = (state_q == scan_tap_pkg::ST_CAPIR);
   assign shIr    = (state_q == scan_tap_pkg::ST_SHIR);
   assign upIr    = (state_q == scan_tap_pkg::ST_UPIR);

   // Reserved codes fall back to bypass so that a path always exists.
   assign selBsr  = (irActive_q == scan_tap_pkg::INS_EXTEST) ||
                    (irActive_q == scan_tap_pkg::INS_SAMPLE) ||
                    (irActive_q == scan_tap_pkg::INS_SAMPLEZ);
   assign selId   = (irActive_q == scan_tap_pkg::INS_IDCODE);
   assign selByp  = !selBsr && !selId;
   assign hiZWant = (irActive_q == scan_tap_pkg::INS_EXTEST) ||
                    (irActive_q == scan_tap_pkg::INS_SAMPLEZ);

   always_ff @(posedge tck or posedge tckRst)
   begin
      if (tckRst)
         irShift_q <= scan_tap_pkg::INS_IDCODE;
      else if (capIr)
         irShift_q <= {irShift_q[scan_tap_pkg::IR_MSB], scan_tap_pkg::IR_CAPTURE_PAT};
      else if (shIr)
         irShift_q <= {tdiEff, irShift_q[scan_tap_pkg::IR_MSB:1]};
   end

   always_ff @(posedge tck or posedge tckRst)
   begin
      if (tckRst)
         irActive_q <= scan_tap_pkg::INS_IDCODE;
      else if (inReset)
         irActive_q <= scan_tap_pkg::INS_IDCODE;
      else if (upIr)
         irActive_q <= irShift_q;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data registers.

   logic                           capDr;
   logic                           shDr;
   logic                           bypass_q;
   logic [scan_tap_pkg::BSR_W-1:0] bsr_q;
   logic [scan_tap_pkg::ID_W-1:0]  idSh_q;
   logic [scan_tap_pkg::BSR_W-1:0] ringCopy_q;

   assign capDr = (state_q == scan_tap_pkg::ST_CAPDR);
   assign shDr  = (state_q == scan_tap_pkg::ST_SHDR);

   always_ff @(posedge tck or posedge tckRst)
   begin
      if (tckRst)
         bypass_q <= 1'b0;
      else if (capDr && selByp)
         bypass_q <= 1'b0;
      else if (shDr && selByp)
         bypass_q <= tdiEff;
   end

   // Update-DR loads nothing, so the ring register is capture and shift only.
   always_ff @(posedge tck or posedge tckRst)
   begin
      if (tckRst)
         bsr_q <= '0;
      else if (capDr && selBsr)
         bsr_q <= ringCopy_q;
      else if (shDr && selBsr)
         bsr_q <= {tdiEff, bsr_q[scan_tap_pkg::BSR_MSB:1]};
   end

   always_ff @(posedge tck or posedge tckRst)
   begin
      if (tckRst)
         idSh_q <= '0;
      else if (capDr && selId)
         idSh_q <= ID_VALUE;
      else if (shDr && selId)
         idSh_q <= {tdiEff, idSh_q[scan_tap_pkg::ID_MSB:1]};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial output on the falling edge.

   logic tdoBit;
   logic tdoEn;

   assign tdoBit = shIr   ? irShift_q[scan_tap_pkg::LSB_POS] :
                   selBsr ? bsr_q[scan_tap_pkg::LSB_POS] :
                   selId  ? idSh_q[scan_tap_pkg::LSB_POS] : bypass_q;
   assign tdoEn  = shIr || shDr;

   always_ff @(negedge tck or posedge tckRst)
   begin
      if (tckRst)
      begin
         tdo   <= 1'b0;
         tdoOe <= 1'b0;
      end
      else
      begin
         tdo   <= tdoBit;
         tdoOe <= tdoEn;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin ring snapshot crossing, toggle handshake.
   // The ring is sampled in the memory clock domain and handed over whole, so the
   // test clock never looks at a moving word; the cost is a snapshot a few
   // test clocks old.

   logic [scan_tap_pkg::BSR_W-1:0] snap_q;
   logic                           reqTgl_q;
   logic                           ackS1_q;
   logic                           ackS2_q;
   logic                           reqS1_q;
   logic                           reqS2_q;
   logic                           ackTgl_q;
   logic                           sysLoad;
   logic                           tckTake;

   assign sysLoad = (ackS2_q == reqTgl_q);
   assign tckTake = (reqS2_q != ackTgl_q);

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         snap_q   <= '0;
         reqTgl_q <= 1'b0;
         ackS1_q  <= 1'b0;
         ackS2_q  <= 1'b0;
      end
      else
      begin
         ackS1_q <= ackTgl_q;
         ackS2_q <= ackS1_q;
         if (sysLoad)
         begin
            snap_q   <= pinRing;
            reqTgl_q <= ~reqTgl_q;
         end
      end
   end

   always_ff @(posedge tck or posedge tckRst)
   begin
      if (tckRst)
      begin
         reqS1_q    <= 1'b0;
         reqS2_q    <= 1'b0;
         ackTgl_q   <= 1'b0;
         ringCopy_q <= '0;
      end
      else
      begin
         reqS1_q <= reqTgl_q;
         reqS2_q <= reqS1_q;
         if (tckTake)
         begin
            ringCopy_q <= snap_q;
            ackTgl_q   <= reqS2_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output float request into the memory clock domain.

   logic hiZReq_q;
   logic hiZS1_q;
   logic hiZS2_q;

   always_ff @(posedge tck or posedge tckRst)
   begin
      if (tckRst)
         hiZReq_q <= 1'b0;
      else
         hiZReq_q <= hiZWant;
   end

   // Only the float level crosses; the memory datapath is never touched here.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         hiZS1_q <= 1'b0;
         hiZS2_q <= 1'b0;
      end
      else
      begin
         hiZS1_q <= hiZReq_q;
         hiZS2_q <= hiZS1_q;
      end
   end

   assign memOutHiZ = hiZS2_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_fiveReset;
      @(posedge tck) disable iff (tckRst)
      tmsEff [*5] |=> (state_q == scan_tap_pkg::ST_TLR);
   endproperty
   a_fiveReset: assert property (p_fiveReset) else $error("five high TMS did not reset");

   property p_resetIdcode;
      @(posedge tck) disable iff (tckRst)
      inReset |=> (irActive_q == scan_tap_pkg::INS_IDCODE);
   endproperty
   a_resetIdcode: assert property (p_resetIdcode) else $error("reset left no IDCODE");

   property p_captureIr;
      @(posedge tck) disable iff (tckRst)
      capIr |=> (irShift_q[1:0] == scan_tap_pkg::IR_CAPTURE_PAT);
   endproperty
   a_captureIr: assert property (p_captureIr) else $error("capture-IR pattern wrong");

   property p_tdoEnable;
      @(posedge tck) disable iff (tckRst)
      ##1 (tdoOe == (shIr || shDr));
   endproperty
   a_tdoEnable: assert property (p_tdoEnable) else $error("TDO enable outside shift");

   property p_bypassClear;
      @(posedge tck) disable iff (tckRst)
      (capDr && selByp) |=> !bypass_q;
   endproperty
   a_bypassClear: assert property (p_bypassClear) else $error("bypass not cleared");

   property p_idCapture;
      @(posedge tck) disable iff (tckRst)
      (capDr && selId) |=> (idSh_q == ID_VALUE);
   endproperty
   a_idCapture: assert property (p_idCapture) else $error("ID code not captured");

   property p_irHold;
      @(posedge tck) disable iff (tckRst)
      (!upIr && !inReset) |=> $stable(irActive_q);
   endproperty
   a_irHold: assert property (p_irHold) else $error("instruction changed early");

   property p_irUpdate;
      @(posedge tck) disable iff (tckRst)
      upIr |=> (irActive_q == $past(irShift_q));
   endproperty
   a_irUpdate: assert property (p_irUpdate) else $error("update-IR lost instruction");

   property p_bsrShiftIn;
      @(posedge tck) disable iff (tckRst)
      (shDr && selBsr) |=> (bsr_q[scan_tap_pkg::BSR_MSB] == $past(tdiEff));
   endproperty
   a_bsrShiftIn: assert property (p_bsrShiftIn) else $error("TDI not at MSB");

   property p_tdoLsb;
      @(posedge tck) disable iff (tckRst)
      (tdoOe && shDr && selBsr) |-> (tdo == bsr_q[scan_tap_pkg::LSB_POS]);
   endproperty
   a_tdoLsb: assert property (p_tdoLsb) else $error("TDO not LSB");

   property p_hiZCross;
      @(posedge clk_sys) disable iff (reset)
      $rose(hiZReq_q) |-> ##[1:4] memOutHiZ;
   endproperty
   a_hiZCross: assert property (p_hiZCross) else $error("output float late");

endmodule

// *** verif/scan_ctrl_model.sv ***
// Behavioural board-side test controller that drives the scan port.
`timescale 1ns/10ps

module scan_ctrl_model (
   input  wire logic tck,
   input  wire logic tdo,
   input  wire logic tdoOe,
   output logic      tmsDrv,
   output logic      tmsDrvEn,
   output logic      tdiDrv,
   output logic      tdiDrvEn
);
   typedef logic [scan_tap_pkg::BSR_W-1:0] vec_t;

   logic sTdo;
   logic sOe;
   bit   floatTms;
   bit   floatTdi;

   initial
   begin
      tmsDrv   = 1'b1;
      tmsDrvEn = 1'b1;
      tdiDrv   = 1'b1;
      tdiDrvEn = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // A released line toggles every cycle, so only the pull-up can make it read high.
   task automatic step(input logic ms, input logic di);
      @(posedge tck);
      sTdo     = tdo;
      sOe      = tdoOe;
      tmsDrvEn <= !floatTms;
      tmsDrv   <= floatTms ? ~tmsDrv : ms;
      tdiDrvEn <= !floatTdi;
      tdiDrv   <= floatTdi ? ~tdiDrv : di;
   endtask

   task automatic go_reset();
      repeat (5) step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Starts and ends in the idle state; the last bit leaves shifting with mode high.
   task automatic scan(input bit ir, input int n, input vec_t din,
                       output vec_t dout, output bit oeOk);
      oeOk = 1'b1;
      dout = '0;
      step(1'b1, 1'b1);
      if (ir)
         step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      step(1'b0, 1'b1);
      for (int i = 0; i <= n; i++)
      begin
         step(i >= n - 1, (i < n) ? din[i] : 1'b1);
         if (i == 0)
            oeOk &= !sOe;
         else
         begin
            dout[i-1] = sTdo;
            oeOk &= sOe;
         end
      end
      step(1'b0, 1'b1);
      oeOk &= !sOe;
   endtask
endmodule

// *** verif/sram_scan_tap_tb_top.sv ***
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/10ps

module sram_scan_tap_tb_top;
   typedef logic [scan_tap_pkg::BSR_W-1:0] vec_t;

   // Identification value handed to the port; the value is arbitrary.
   localparam logic [31:0] ID_V = 32'h1357_9BDF;
   localparam vec_t        RING = 75'h5_A5C3_96F0_1E2D_3C4B_5A;
   // The top bit is set so that the bypass cell holds a one before its next capture.
   localparam vec_t        DIN  = 75'h6_3F81_C7E0_55AA_9B6D_C4;

   logic clk_sys;
   logic reset;
   logic tck;
   logic tmsDrv;
   logic tmsDrvEn;
   logic tdiDrv;
   logic tdiDrvEn;
   logic tdo;
   logic tdoOe;
   logic memOutHiZ;
   vec_t pinRing;
   vec_t dout;
   bit   oeOk;
   logic [1:0] pre;
   int   nFail;
   int   totalChecks;
   int   cycles;

   sram_scan_tap #(.ID_VALUE(ID_V)) uut (
      .clk_sys(clk_sys), .reset(reset), .tck(tck), .tmsDrv(tmsDrv),
      .tmsDrvEn(tmsDrvEn), .tdiDrv(tdiDrv), .tdiDrvEn(tdiDrvEn), .tdo(tdo),
      .tdoOe(tdoOe), .pinRing(pinRing), .memOutHiZ(memOutHiZ));

   scan_ctrl_model ctrl (
      .tck(tck), .tdo(tdo), .tdoOe(tdoOe), .tmsDrv(tmsDrv),
      .tmsDrvEn(tmsDrvEn), .tdiDrv(tdiDrv), .tdiDrvEn(tdiDrvEn));

   initial clk_sys = 1'b0;
   always #50 clk_sys = ~clk_sys;
   initial tck = 1'b0;
   always #80 tck = ~tck;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input vec_t exp, input vec_t got);
      totalChecks++;
      if (got !== exp)
      begin
         nFail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bits seen leaving the port when a register of len bits holding cap is shifted.
   function automatic vec_t exp_scan(input int len, input vec_t cap, input vec_t din);
      vec_t r;
      for (int i = 0; i < scan_tap_pkg::BSR_W; i++)
         r[i] = (i < len) ? cap[i] : din[i-len];
      return r;
   endfunction

   task automatic test_done();
      $display("Checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic load(input logic [2:0] c);
      ctrl.scan(1'b1, 3, vec_t'(c), dout, oeOk);
      chk("ir capture", 75'h1, vec_t'(dout[1:0]));
      chk("ir enable", 75'h1, vec_t'(oeOk));
   endtask

   // The float level crosses into the memory clock, so allow it time to settle.
   task automatic wait_mem();
      repeat (12) @(negedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // The output must not move while the test clock is high.
   always @(posedge tck)
   begin
      pre = {tdoOe, tdo};
      #5;
      if (!reset)
         chk("edge", vec_t'(pre), vec_t'({tdoOe, tdo}));
   end

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         nFail++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_power();
      chk("idle enable", 75'h0, vec_t'(tdoOe));
      chk("idle float", 75'h0, vec_t'(memOutHiZ));
      ctrl.go_reset();
      ctrl.scan(1'b0, 75, DIN, dout, oeOk);
      chk("power id", exp_scan(32, vec_t'(ID_V), DIN), dout);
      $display("Test power done");
   endtask

   task automatic t_codes();
      logic [2:0] c;
      int         len;
      vec_t       cap;
      for (int k = 0; k < 8; k++)
      begin
         c = 3'(k);
         load(c);
         wait_mem();
         len = 1;
         cap = '0;
         if (c === scan_tap_pkg::INS_IDCODE)
         begin
            len = 32;
            cap = vec_t'(ID_V);
         end
         else if (c inside {scan_tap_pkg::INS_EXTEST, scan_tap_pkg::INS_SAMPLEZ,
                            scan_tap_pkg::INS_SAMPLE})
         begin
            len = 75;
            cap = RING;
         end
         chk("float", vec_t'(c inside {scan_tap_pkg::INS_EXTEST, scan_tap_pkg::INS_SAMPLEZ}),
             vec_t'(memOutHiZ));
         ctrl.scan(1'b0, 75, DIN, dout, oeOk);
         chk("shift", exp_scan(len, cap, DIN), dout);
         chk("dr enable", 75'h1, vec_t'(oeOk));
      end
      $display("Test codes done");
   endtask

   // An instruction parked in the pause state must not take effect before update.
   task automatic t_pause();
      ctrl.step(1'b1, 1'b1);
      ctrl.step(1'b1, 1'b1);
      ctrl.step(1'b0, 1'b1);
      ctrl.step(1'b0, 1'b1);
      ctrl.step(1'b0, 1'b0);
      ctrl.step(1'b0, 1'b0);
      ctrl.step(1'b1, 1'b0);
      repeat (7) ctrl.step(1'b0, 1'b1);
      chk("pause float", 75'h0, vec_t'(memOutHiZ));
      ctrl.step(1'b1, 1'b1);
      ctrl.step(1'b1, 1'b1);
      ctrl.step(1'b0, 1'b1);
      wait_mem();
      chk("update float", 75'h1, vec_t'(memOutHiZ));
      $display("Test pause done");
   endtask

   task automatic t_float();
      ctrl.floatTms = 1'b1;
      ctrl.floatTdi = 1'b1;
      repeat (5) ctrl.step(1'b0, 1'b0);
      ctrl.floatTms = 1'b0;
      ctrl.step(1'b0, 1'b0);
      wait_mem();
      chk("reset float", 75'h0, vec_t'(memOutHiZ));
      ctrl.scan(1'b0, 75, DIN, dout, oeOk);
      chk("open id", exp_scan(32, vec_t'(ID_V), '1), dout);
      ctrl.floatTdi = 1'b0;
      $display("Test float done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      nFail = 0;
      totalChecks = 0;
      cycles = 0;
      reset = 1'b1;
      pinRing = RING;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge tck);
      t_power();
      t_codes();
      t_pause();
      t_float();
      test_done();
   end
endmodule
